// ===== hdl/vie_gamma_lut.sv
`timescale 1ns/10ps
`default_nettype none
module vie_gamma_lut (
   input wire logic clk_sys,
   input wire logic sw_we,
   input wire vie_pkg::vie_lut_sel_t sw_sel,
   input wire logic [7:0] sw_idx,
   input wire logic [7:0] sw_wdata,
   output logic [7:0] sw_rdata,
   input wire vie_pkg::vie_rgb_t pix_in,
   output vie_pkg::vie_rgb_t pix_out
);
   import vie_pkg::*;
   // three 256-entry tables in flip-flops, index 0 red, 1 green, 2 blue
   logic [7:0] tab_q [3][256];

   // software write, code 11 writes the entry into all three tables
   always_ff @(posedge clk_sys) begin
      for (int c = 0; c < 3; c++) begin
         if (sw_we && (sw_sel == VIE_LUT_ALL || int'(sw_sel) == c)) begin
            tab_q[c][sw_idx] <= sw_wdata;
         end
      end
   end

   // software read; the all-tables code has no readable source
   always_comb begin
      case (sw_sel)
         VIE_LUT_RED: sw_rdata = tab_q[0][sw_idx];
         VIE_LUT_GREEN: sw_rdata = tab_q[1][sw_idx];
         VIE_LUT_BLUE: sw_rdata = tab_q[2][sw_idx];
         default: sw_rdata = 8'h00;
      endcase
   end

   // pixel lookup
   assign pix_out.r = tab_q[0][pix_in.r];
   assign pix_out.g = tab_q[1][pix_in.g];
   assign pix_out.b = tab_q[2][pix_in.b];
endmodule : vie_gamma_lut
`default_nettype wire

// ===== hdl/vie_pipeline.sv
//Contract
//- luma offset is offset-binary, 0x80 adds nothing, range -128 to +127.
//- mid-range luma gain 0x80 is unity, 0x00 zero, 0xff about 1.99.
//- separate white and black range slopes, 0x80 unity each.
//- white knee is 0xe0 plus the 5-bit field.
//- black knee equals the 5-bit field, 0x00 to 0x1f.
//- red, green, blue each get own offset and gain, reset 0x80.
//- gain type bit picks type 1 when clear, type 2 when set.
//- sharpening gated by enable, 7-bit strength, 6-bit threshold.
//- U and V saturation gains, 0x40 unity, 0x7f about 1.98.
//- link bit set applies U gain to both U and V.
//- colour kill acts only while its enable bit is set.
//- transient levels per U and V, 000 least, 111 most.
//- transient improvement runs only when enabled, uses 8-bit threshold.
//- conversion variant bit, 0 takes luma as is, 1 expands studio-range luma.
//- gamma table at 0x100-0x1ff, software owns it while correction off.
//- channel select routes red, green, blue; 11 writes all, no reads.
//- dither for 6-bit panels, separate even and odd field factors.
//- mask bit set suppresses dither inside the overlay area.
//- DAC fix uses offset and slope, central or normal slope kind.
//- output bounded by low field and 256 plus span.
//- clamp bit gives unity clamp; map bit alone maps linearly.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module vie_pipeline (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire vie_pkg::vie_bus_t bus,
   output logic [7:0] rdata,
   input wire logic [7:0] pre_y,
   input wire logic pre_valid,
   output logic [7:0] pre_out_y,
   output logic pre_out_valid,
   input wire vie_pkg::vie_yuv_t pix_in,
   input wire logic pix_in_valid,
   input wire logic field_odd,
   input wire logic on_screen_overlay,
   output vie_pkg::vie_rgb_t pix_out,
   output logic pix_out_valid
);
   import vie_pkg::*;

   // saturate a signed value to an 8-bit code
   function automatic logic [7:0] sat8(input logic signed [11:0] x);
      if (x < 0) return 8'h00;
      if (x > 12'sd255) return 8'hff;
      return x[7:0];
   endfunction : sat8

   // multiply by a gain whose unity sits at bit 7
   function automatic logic signed [11:0] gain7(input logic signed [11:0] x,
                                                input logic [7:0] g);
      logic signed [20:0] p;
      p = x * $signed({1'b0, g});
      return p[18:7];
   endfunction : gain7

   // signed distance of a code from mid scale
   function automatic logic signed [11:0] ctr(input logic [7:0] x);
      return $signed({4'h0, x}) - 12'sd128;
   endfunction : ctr

   // control registers
   logic [7:0] post_ofs_q [3];
   logic [7:0] post_gain_q [3];
   logic [7:0] luma_offset_q, luma_mid_gain_q, luma_high_slope_q, luma_low_slope_q;
   logic [4:0] luma_high_knee_q, luma_low_knee_q;
   logic [6:0] sharpen_strength_q, u_chroma_gain_q, v_chroma_gain_q, out_range_low_q;
   logic sharpen_on_q, chroma_gain_link_q, transient_on_q, out_linear_map_on_q;
   logic [5:0] sharpen_threshold_q;
   logic [7:0] transient_threshold_q, dither_even_factor_q, dither_odd_factor_q;
   logic [2:0] transient_u_level_q, transient_v_level_q;
   logic [7:0] mode_q;
   logic [7:0] out_range_span_q, dac_offset_factor_q, dac_slope_factor_q;
   logic dac_fix_on_q, dac_slope_kind_q, out_clamp_on_q;
   logic [7:0] rdata_q;
   logic [7:0] lut_rdata;
   logic lut_win, lut_we;

   assign lut_win = bus.addr[LUT_WIN_BIT];
   // table reachable by software only while correction is off
   assign lut_we = bus.wr && lut_win && !mode_q[F_MODE_LUT];

   // register writes
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         for (int c = 0; c < 3; c++) begin
            post_ofs_q[c] <= RST_UNITY;
            post_gain_q[c] <= RST_UNITY;
         end
         luma_offset_q <= RST_UNITY;
         luma_mid_gain_q <= RST_UNITY;
         luma_high_slope_q <= RST_UNITY;
         luma_low_slope_q <= RST_UNITY;
         luma_high_knee_q <= 5'h00;
         luma_low_knee_q <= 5'h00;
         sharpen_strength_q <= 7'h00;
         sharpen_on_q <= 1'b0;
         sharpen_threshold_q <= 6'h00;
         u_chroma_gain_q <= RST_SAT;
         v_chroma_gain_q <= RST_SAT;
         chroma_gain_link_q <= 1'b1;
         transient_threshold_q <= RST_TRANS_THR;
         transient_u_level_q <= RST_TRANS_LVL;
         transient_v_level_q <= RST_TRANS_LVL;
         transient_on_q <= 1'b0;
         mode_q <= 8'h20; // only the overlay mask bit set
         dither_even_factor_q <= RST_DITHER_EVEN;
         dither_odd_factor_q <= RST_DITHER_ODD;
         out_range_span_q <= RST_RANGE_SPAN;
         out_range_low_q <= RST_RANGE_LOW;
         out_linear_map_on_q <= 1'b0;
         dac_offset_factor_q <= RST_UNITY;
         dac_slope_factor_q <= RST_UNITY;
         dac_fix_on_q <= 1'b0;
         dac_slope_kind_q <= 1'b0;
         out_clamp_on_q <= 1'b0;
      end else if (bus.wr && !lut_win) begin
         case (bus.addr)
            A_POST_R_OFS: post_ofs_q[0] <= bus.wdata;
            A_POST_G_OFS: post_ofs_q[1] <= bus.wdata;
            A_POST_B_OFS: post_ofs_q[2] <= bus.wdata;
            A_POST_R_GAIN: post_gain_q[0] <= bus.wdata;
            A_POST_G_GAIN: post_gain_q[1] <= bus.wdata;
            A_POST_B_GAIN: post_gain_q[2] <= bus.wdata;
            A_LUMA_OFS: luma_offset_q <= bus.wdata;
            A_LUMA_MID: luma_mid_gain_q <= bus.wdata;
            A_LUMA_HSLOPE: luma_high_slope_q <= bus.wdata;
            A_LUMA_LSLOPE: luma_low_slope_q <= bus.wdata;
            A_LUMA_HKNEE: luma_high_knee_q <= bus.wdata[4:0];
            A_LUMA_LKNEE: luma_low_knee_q <= bus.wdata[4:0];
            A_SHARPEN: begin
               sharpen_strength_q <= bus.wdata[6:0];
               sharpen_on_q <= bus.wdata[F_ENABLE];
            end
            A_SHARPEN_THR: sharpen_threshold_q <= bus.wdata[5:0];
            A_U_GAIN: begin
               u_chroma_gain_q <= bus.wdata[6:0];
               chroma_gain_link_q <= bus.wdata[F_ENABLE];
            end
            A_V_GAIN: v_chroma_gain_q <= bus.wdata[6:0];
            A_TRANS_THR: transient_threshold_q <= bus.wdata;
            A_TRANS: begin
               transient_u_level_q <= bus.wdata[2:0];
               transient_v_level_q <= bus.wdata[F_TRANS_V +: 3];
               transient_on_q <= bus.wdata[F_ENABLE];
            end
            A_MODE: mode_q <= bus.wdata;
            A_DITHER_EVEN: dither_even_factor_q <= bus.wdata;
            A_DITHER_ODD: dither_odd_factor_q <= bus.wdata;
            A_RANGE_SPAN: out_range_span_q <= bus.wdata;
            A_RANGE_LOW: begin
               out_range_low_q <= bus.wdata[6:0];
               out_linear_map_on_q <= bus.wdata[F_ENABLE];
            end
            A_DAC_OFS: dac_offset_factor_q <= bus.wdata;
            A_DAC_SLOPE: dac_slope_factor_q <= bus.wdata;
            A_OUT_CTRL: begin
               dac_fix_on_q <= bus.wdata[F_DAC_ON];
               dac_slope_kind_q <= bus.wdata[F_DAC_KIND];
               out_clamp_on_q <= bus.wdata[F_CLAMP_ON];
            end
            default: ;
         endcase
      end
   end

   // read data, one cycle after the strobe; unmapped reads zero
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         rdata_q <= 8'h00;
      end else if (!bus.rd) begin
         rdata_q <= 8'h00;
      end else if (lut_win) begin
         rdata_q <= mode_q[F_MODE_LUT] ? 8'h00 : lut_rdata;
      end else begin
         case (bus.addr)
            A_POST_R_OFS: rdata_q <= post_ofs_q[0];
            A_POST_G_OFS: rdata_q <= post_ofs_q[1];
            A_POST_B_OFS: rdata_q <= post_ofs_q[2];
            A_POST_R_GAIN: rdata_q <= post_gain_q[0];
            A_POST_G_GAIN: rdata_q <= post_gain_q[1];
            A_POST_B_GAIN: rdata_q <= post_gain_q[2];
            A_LUMA_OFS: rdata_q <= luma_offset_q;
            A_LUMA_MID: rdata_q <= luma_mid_gain_q;
            A_LUMA_HSLOPE: rdata_q <= luma_high_slope_q;
            A_LUMA_LSLOPE: rdata_q <= luma_low_slope_q;
            A_LUMA_HKNEE: rdata_q <= {3'h0, luma_high_knee_q};
            A_LUMA_LKNEE: rdata_q <= {3'h0, luma_low_knee_q};
            A_SHARPEN: rdata_q <= {sharpen_on_q, sharpen_strength_q};
            A_SHARPEN_THR: rdata_q <= {2'h0, sharpen_threshold_q};
            A_U_GAIN: rdata_q <= {chroma_gain_link_q, u_chroma_gain_q};
            A_V_GAIN: rdata_q <= {1'b0, v_chroma_gain_q};
            A_TRANS_THR: rdata_q <= transient_threshold_q;
            A_TRANS: rdata_q <= {transient_on_q, transient_v_level_q, 1'b0,
                                 transient_u_level_q};
            A_MODE: rdata_q <= mode_q;
            A_DITHER_EVEN: rdata_q <= dither_even_factor_q;
            A_DITHER_ODD: rdata_q <= dither_odd_factor_q;
            A_RANGE_SPAN: rdata_q <= out_range_span_q;
            A_RANGE_LOW: rdata_q <= {out_linear_map_on_q, out_range_low_q};
            A_DAC_OFS: rdata_q <= dac_offset_factor_q;
            A_DAC_SLOPE: rdata_q <= dac_slope_factor_q;
            A_OUT_CTRL: rdata_q <= {5'h00, out_clamp_on_q, dac_slope_kind_q, dac_fix_on_q};
            default: rdata_q <= 8'h00;
         endcase
      end
   end
   assign rdata = rdata_q;

   // pre-scaler luma: offset then three-segment transfer curve
   logic signed [11:0] y_ofs, y_mid, knee_lo, knee_hi, y_curve;
   logic [7:0] pre_y_q;
   logic pre_valid_q;
   always_comb begin
      y_ofs = $signed({4'h0, pre_y}) + ctr(luma_offset_q);
      knee_lo = $signed({7'h00, luma_low_knee_q});
      knee_hi = $signed({4'h0, HKNEE_BASE}) + $signed({7'h00, luma_high_knee_q});
      y_mid = gain7(y_ofs - 12'sd128, luma_mid_gain_q) + 12'sd128;
      if (y_ofs < knee_lo) begin
         y_curve = gain7(knee_lo - 12'sd128, luma_mid_gain_q) + 12'sd128
                   - gain7(knee_lo - y_ofs, luma_low_slope_q);
      end else if (y_ofs > knee_hi) begin
         y_curve = gain7(knee_hi - 12'sd128, luma_mid_gain_q) + 12'sd128
                   + gain7(y_ofs - knee_hi, luma_high_slope_q);
      end else begin
         y_curve = y_mid;
      end
   end

   // pre stage output register, feeds the scaler
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         pre_y_q <= 8'h00;
         pre_valid_q <= 1'b0;
      end else begin
         pre_valid_q <= pre_valid;
         if (pre_valid) pre_y_q <= sat8(y_curve);
      end
   end
   assign pre_out_y = pre_y_q;
   assign pre_out_valid = pre_valid_q;

   // stage 1: luma sharpening and chroma path, against the previous pixel
   vie_yuv_t prev_q, s1_q;
   logic signed [11:0] dy, du, dv, y_sh, u_sat, v_sat, u_ct, v_ct;
   logic [6:0] v_gain;
   always_comb begin
      dy = $signed({4'h0, pix_in.y}) - $signed({4'h0, prev_q.y});
      du = $signed({4'h0, pix_in.u}) - $signed({4'h0, prev_q.u});
      dv = $signed({4'h0, pix_in.v}) - $signed({4'h0, prev_q.v});
      y_sh = $signed({4'h0, pix_in.y});
      if (sharpen_on_q && (dy > $signed({6'h00, sharpen_threshold_q})
                           || -dy > $signed({6'h00, sharpen_threshold_q}))) begin
         y_sh = y_sh + gain7(dy, {1'b0, sharpen_strength_q});
      end
      v_gain = chroma_gain_link_q ? u_chroma_gain_q : v_chroma_gain_q;
      u_sat = gain7(ctr(pix_in.u), {u_chroma_gain_q, 1'b0});
      v_sat = gain7(ctr(pix_in.v), {v_gain, 1'b0});
      u_ct = u_sat;
      v_ct = v_sat;
      if (transient_on_q) begin
         if (du > $signed({4'h0, transient_threshold_q})
             || -du > $signed({4'h0, transient_threshold_q})) begin
            u_ct = u_sat + gain7(du, {4'h0, transient_u_level_q, 1'b0});
         end
         if (dv > $signed({4'h0, transient_threshold_q})
             || -dv > $signed({4'h0, transient_threshold_q})) begin
            v_ct = v_sat + gain7(dv, {4'h0, transient_v_level_q, 1'b0});
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         prev_q <= '0;
         s1_q <= '0;
      end else if (pix_in_valid) begin
         prev_q <= pix_in;
         s1_q.y <= sat8(y_sh);
         s1_q.u <= mode_q[F_MODE_KILL] ? MID_CODE : sat8(u_ct + 12'sd128);
         s1_q.v <= mode_q[F_MODE_KILL] ? MID_CODE : sat8(v_ct + 12'sd128);
      end
   end

   // stage 2: colour conversion, variant 1 expands studio-range luma
   logic signed [11:0] cy, cu, cv;
   logic signed [19:0] cr_p, cg_p, cb_p;
   vie_rgb_t s2_q;
   always_comb begin
      cu = ctr(s1_q.u);
      cv = ctr(s1_q.v);
      if (mode_q[F_MODE_CSC]) begin
         cr_p = ($signed({4'h0, s1_q.y}) - 12'sd16) * 20'sd298;
         cy = cr_p[19:8];
      end else begin
         cr_p = 20'sd0;
         cy = $signed({4'h0, s1_q.y});
      end
      cg_p = cu * 20'sd88 + cv * 20'sd183;
      cb_p = cu * 20'sd454;
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         s2_q <= '0;
      end else begin
         s2_q.r <= sat8(cy + 12'((cv * 20'sd359) >>> 8));
         s2_q.g <= sat8(cy - cg_p[19:8]);
         s2_q.b <= sat8(cy + cb_p[19:8]);
      end
   end

   // stage 3: per-channel gain and offset
   logic [7:0] s2_ch [3];
   logic [7:0] s3_ch_q [3];
   assign s2_ch[0] = s2_q.r;
   assign s2_ch[1] = s2_q.g;
   assign s2_ch[2] = s2_q.b;
   always_ff @(posedge clk_sys) begin
      for (int c = 0; c < 3; c++) begin
         if (!rstn) begin
            s3_ch_q[c] <= 8'h00;
         end else if (mode_q[F_MODE_GTYPE]) begin
            s3_ch_q[c] <= sat8(gain7($signed({4'h0, s2_ch[c]}), post_gain_q[c])
                               + ctr(post_ofs_q[c]));
         end else begin
            s3_ch_q[c] <= sat8(gain7(ctr(s2_ch[c]), post_gain_q[c]) + 12'sd128
                               + ctr(post_ofs_q[c]));
         end
      end
   end

   // stage 4: gamma lookup
   vie_rgb_t lut_in, lut_out, s4_q;
   assign lut_in = {s3_ch_q[0], s3_ch_q[1], s3_ch_q[2]};
   vie_gamma_lut i_vie_gamma_lut (
      .clk_sys(clk_sys),
      .sw_we(lut_we),
      .sw_sel(vie_lut_sel_t'(mode_q[F_MODE_SEL +: 2])),
      .sw_idx(bus.addr[7:0]),
      .sw_wdata(bus.wdata),
      .sw_rdata(lut_rdata),
      .pix_in(lut_in),
      .pix_out(lut_out)
   );
   always_ff @(posedge clk_sys) begin
      if (!rstn) s4_q <= '0;
      else s4_q <= mode_q[F_MODE_LUT] ? lut_out : lut_in;
   end

   // side signals travel with the pixel up to the dither stage
   logic [POST_STAGES-1:0] vld_q;
   logic [3:0] osd_q, odd_q;
   logic [1:0] dcnt_q;
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         vld_q <= '0;
         osd_q <= '0;
         odd_q <= '0;
         dcnt_q <= 2'h0;
      end else begin
         vld_q <= {vld_q[POST_STAGES-2:0], pix_in_valid};
         osd_q <= {osd_q[2:0], on_screen_overlay};
         odd_q <= {odd_q[2:0], field_odd};
         if (vld_q[3]) dcnt_q <= dcnt_q + 2'h1;
      end
   end

   // stage 5: dither into the top six bits
   logic [7:0] dfac;
   logic [1:0] dval;
   logic dith_act;
   vie_rgb_t s5_q;
   always_comb begin
      dfac = odd_q[3] ? dither_odd_factor_q : dither_even_factor_q;
      dval = dfac[{dcnt_q, 1'b0} +: 2];
      dith_act = mode_q[F_MODE_DITHER] && !(mode_q[F_MODE_MASK] && osd_q[3]);
   end
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         s5_q <= '0;
      end else if (dith_act) begin
         s5_q.r <= sat8($signed({4'h0, s4_q.r}) + $signed({10'h0, dval})) & 8'hfc;
         s5_q.g <= sat8($signed({4'h0, s4_q.g}) + $signed({10'h0, dval})) & 8'hfc;
         s5_q.b <= sat8($signed({4'h0, s4_q.b}) + $signed({10'h0, dval})) & 8'hfc;
      end else begin
         s5_q <= s4_q;
      end
   end

   // stage 6: DAC error correction
   logic [7:0] s5_ch [3];
   logic [7:0] s6_ch_q [3];
   assign s5_ch[0] = s5_q.r;
   assign s5_ch[1] = s5_q.g;
   assign s5_ch[2] = s5_q.b;
   always_ff @(posedge clk_sys) begin
      for (int c = 0; c < 3; c++) begin
         if (!rstn) begin
            s6_ch_q[c] <= 8'h00;
         end else if (!dac_fix_on_q) begin
            s6_ch_q[c] <= s5_ch[c];
         end else if (dac_slope_kind_q) begin
            s6_ch_q[c] <= sat8(gain7($signed({4'h0, s5_ch[c]}), dac_slope_factor_q)
                               + ctr(dac_offset_factor_q));
         end else begin
            s6_ch_q[c] <= sat8(gain7(ctr(s5_ch[c]), dac_slope_factor_q) + 12'sd128
                               + ctr(dac_offset_factor_q));
         end
      end
   end

   // stage 7: output clamp or linear range mapping
   logic signed [11:0] rmin, rmax;
   logic signed [11:0] r_out [3];
   logic signed [23:0] rmap;
   always_comb begin
      rmin = $signed({5'h00, out_range_low_q});
      rmax = 12'sd256 + $signed({4'h0, out_range_span_q});
      rmap = 24'sd0;
      for (int c = 0; c < 3; c++) begin
         r_out[c] = $signed({4'h0, s6_ch_q[c]});
         if (out_clamp_on_q) begin
            if (r_out[c] < rmin) r_out[c] = rmin;
            else if (r_out[c] > rmax) r_out[c] = rmax;
         end else if (out_linear_map_on_q) begin
            rmap = $signed({12'h000, s6_ch_q[c]}) * (rmax - rmin);
            r_out[c] = rmin + rmap[19:8];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         pix_out <= '0;
         pix_out_valid <= 1'b0;
      end else begin
         pix_out <= {sat8(r_out[0]), sat8(r_out[1]), sat8(r_out[2])};
         pix_out_valid <= vld_q[POST_STAGES-2];
      end
   end
endmodule : vie_pipeline
`default_nettype wire

// ===== hdl/vie_pkg.sv
package vie_pkg;
   // register offsets of the control block
   localparam logic [8:0] A_POST_R_OFS = 9'h07c;
   localparam logic [8:0] A_POST_G_OFS = 9'h07d;
   localparam logic [8:0] A_POST_B_OFS = 9'h07e;
   localparam logic [8:0] A_POST_R_GAIN = 9'h07f;
   localparam logic [8:0] A_POST_G_GAIN = 9'h080;
   localparam logic [8:0] A_POST_B_GAIN = 9'h081;
   localparam logic [8:0] A_LUMA_OFS = 9'h082;
   localparam logic [8:0] A_LUMA_MID = 9'h083;
   localparam logic [8:0] A_LUMA_HSLOPE = 9'h084;
   localparam logic [8:0] A_LUMA_LSLOPE = 9'h085;
   localparam logic [8:0] A_LUMA_HKNEE = 9'h086;
   localparam logic [8:0] A_LUMA_LKNEE = 9'h087;
   localparam logic [8:0] A_SHARPEN = 9'h08a;
   localparam logic [8:0] A_SHARPEN_THR = 9'h08b;
   localparam logic [8:0] A_U_GAIN = 9'h08c;
   localparam logic [8:0] A_V_GAIN = 9'h08d;
   localparam logic [8:0] A_TRANS_THR = 9'h08e;
   localparam logic [8:0] A_TRANS = 9'h08f;
   localparam logic [8:0] A_MODE = 9'h090;
   localparam logic [8:0] A_DITHER_EVEN = 9'h091;
   localparam logic [8:0] A_DITHER_ODD = 9'h092;
   localparam logic [8:0] A_RANGE_SPAN = 9'h093;
   localparam logic [8:0] A_RANGE_LOW = 9'h094;
   localparam logic [8:0] A_DAC_OFS = 9'h095;
   localparam logic [8:0] A_DAC_SLOPE = 9'h096;
   localparam logic [8:0] A_OUT_CTRL = 9'h097;
   // gamma table window 0x100..0x1ff is selected by this address bit
   localparam int LUT_WIN_BIT = 8;
   // field positions
   localparam int F_ENABLE = 7;
   localparam int F_TRANS_V = 4;
   localparam int F_MODE_GTYPE = 0;
   localparam int F_MODE_DITHER = 1;
   localparam int F_MODE_LUT = 2;
   localparam int F_MODE_SEL = 3;
   localparam int F_MODE_MASK = 5;
   localparam int F_MODE_KILL = 6;
   localparam int F_MODE_CSC = 7;
   localparam int F_DAC_ON = 0;
   localparam int F_DAC_KIND = 1;
   localparam int F_CLAMP_ON = 2;
   // reset values
   localparam logic [7:0] RST_UNITY = 8'h80;
   localparam logic [6:0] RST_SAT = 7'h40;
   localparam logic [7:0] RST_TRANS_THR = 8'h01;
   localparam logic [2:0] RST_TRANS_LVL = 3'h7;
   localparam logic [7:0] RST_DITHER_EVEN = 8'h87;
   localparam logic [7:0] RST_DITHER_ODD = 8'h78;
   localparam logic [7:0] RST_RANGE_SPAN = 8'h99;
   localparam logic [6:0] RST_RANGE_LOW = 7'h67;
   // fixed luma points
   localparam logic [7:0] HKNEE_BASE = 8'he0;
   localparam logic [7:0] MID_CODE = 8'h80;
   localparam int POST_STAGES = 7;
   // gamma table channel select codes
   typedef enum logic [1:0] {
      VIE_LUT_RED = 2'h0,
      VIE_LUT_GREEN = 2'h1,
      VIE_LUT_BLUE = 2'h2,
      VIE_LUT_ALL = 2'h3
   } vie_lut_sel_t;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [8:0] addr;
      logic [7:0] wdata;
   } vie_bus_t;
   typedef struct packed {
      logic [7:0] y;
      logic [7:0] u;
      logic [7:0] v;
   } vie_yuv_t;
   typedef struct packed {
      logic [7:0] r;
      logic [7:0] g;
      logic [7:0] b;
   } vie_rgb_t;
endpackage : vie_pkg

// ===== tb/tb_vie_pipeline.sv
`timescale 1ns/10ps
`default_nettype none
module tb_vie_pipeline;
   import vie_pkg::*;
`define CHK(a, e) begin t = (e); checks_done++; if ((a) !== t) begin bad_count++; \
$display("ERROR %0t %h %h", $time, a, t); end end
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic pre_valid = 1'b0;
   logic src_on = 1'b0;
   logic rd_d = 1'b0;
   logic [7:0] pre_y = 8'h00;
   logic [7:0] rdata, pre_out_y, d;
   logic [31:0] t;
   logic pre_out_valid, pix_in_valid, field_odd, on_screen_overlay, pix_out_valid;
   vie_bus_t bus = '0;
   vie_yuv_t pix_in;
   vie_rgb_t pix_out;
   logic [7:0] exp_rd[$], exp_y[$];
   logic [23:0] exp_px[$];
   int bad_count = 0, checks_done = 0, n_in = 0, n_out = 0;
   always #20 clk_sys = ~clk_sys;
   vie_pipeline i_vie_pipeline (.clk_sys, .rstn, .bus, .rdata, .pre_y, .pre_valid, .pre_out_y,
      .pre_out_valid, .pix_in, .pix_in_valid, .field_odd, .on_screen_overlay, .pix_out,
      .pix_out_valid);
   vie_scaler_model i_vie_scaler_model (.clk_sys, .src_on, .pix_in, .pix_in_valid,
      .field_odd, .on_screen_overlay);
   // compare outputs with the oldest note
   always @(posedge clk_sys) begin
      rd_d <= bus.rd;
      if (rd_d) `CHK(rdata, exp_rd.pop_front())
      if (pre_out_valid) `CHK(pre_out_y, exp_y.pop_front())
      if (pix_out_valid) `CHK(pix_out, exp_px.pop_front())
      // neutral chroma, unity gains, no table: grey out equals luma in
      if (pix_in_valid === 1'b1) exp_px.push_back({3{pix_in.y}});
      n_in += int'(pix_in_valid === 1'b1);
      n_out += int'(pix_out_valid === 1'b1);
   end
   // one bus or luma request, then an idle cycle
   task automatic acc(input logic w, input logic [8:0] a, input logic [7:0] v);
      bus <= '{w, !w, a, w ? v : 8'h00};
      if (!w) exp_rd.push_back(v);
      @(posedge clk_sys);
      bus <= '0;
      @(posedge clk_sys);
   endtask : acc
   task automatic luma(input logic [7:0] y, input logic [7:0] e);
      pre_valid <= 1'b1;
      pre_y <= y;
      exp_y.push_back(e);
      @(posedge clk_sys);
      pre_valid <= 1'b0;
      @(posedge clk_sys);
   endtask : luma
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_sim
   // main sequence
   initial begin
      void'($urandom(16));
      repeat (3) @(posedge clk_sys);
      rstn <= 1'b1;
      @(posedge clk_sys);
      for (int a = 'h7c; a <= 'h85; a++) acc(0, 9'(a), RST_UNITY);
      acc(0, A_U_GAIN, 8'hc0);
      acc(0, A_TRANS, 8'h77);
      acc(0, A_MODE, 8'h20);
      acc(0, A_RANGE_LOW, RST_RANGE_LOW);
      for (int a = 'h86; a <= 'h87; a++) begin
         acc(1, 9'(a), 8'hff);
         acc(0, 9'(a), 8'h1f);
      end
      d = 8'($urandom);
      acc(1, A_DAC_SLOPE, d);
      acc(0, A_DAC_SLOPE, d);
      $display("done: registers");
      for (int i = 0; i < 6; i++) begin
         d = 8'($urandom);
         luma(d, d);
      end
      acc(1, A_LUMA_OFS, 8'h90);
      luma(8'h40, 8'h50);
      acc(1, A_LUMA_OFS, 8'h00);
      luma(8'ha0, 8'h20);
      $display("done: luma");
      acc(1, A_MODE, 8'h38);
      acc(1, 9'h140, 8'h5a);
      acc(0, 9'h140, 8'h00);
      for (int s = 0; s < 3; s++) begin
         acc(1, A_MODE, 8'(8'h20 | (s << 3)));
         acc(0, 9'h140, 8'h5a);
      end
      acc(1, A_MODE, 8'h24);
      acc(0, 9'h140, 8'h00);
      $display("done: gamma");
      acc(1, A_MODE, 8'h20);
      src_on <= 1'b1;
      repeat (40) @(posedge clk_sys);
      src_on <= 1'b0;
      repeat (10) @(posedge clk_sys);
      `CHK(n_out, n_in)
      $display("done: pixels");
      end_sim();
   end
   // watchdog
   initial begin
      #100000;
      bad_count++;
      end_sim();
   end
endmodule : tb_vie_pipeline
`default_nettype wire

// ===== tb/vie_pipeline_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module vie_pipeline_assertions (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire vie_pkg::vie_bus_t bus,
   input wire logic [7:0] rdata,
   input wire logic pre_valid,
   input wire logic [7:0] pre_out_y,
   input wire logic pre_out_valid,
   input wire logic pix_in_valid,
   input wire logic pix_out_valid
);
   import vie_pkg::*;
   logic [7:0] mode_q;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);
   // shadow of the mode byte
   always_ff @(posedge clk_sys) begin
      if (!rstn)
         mode_q <= 8'h20;
      else if (bus.wr && bus.addr == A_MODE)
         mode_q <= bus.wdata;
   end
   // bus answers
   rd_idle_a: assert property (!bus.rd |=> rdata == 8'h00)
      else $error("read data not cleared");
   lut_busy_a: assert property (bus.rd && bus.addr[8] && mode_q[2] |=> !rdata)
      else $error("table read while correcting");
   lut_all_a: assert property (bus.rd && bus.addr[8] && mode_q[4:3] == 2'h3 |=> !rdata)
      else $error("table read with all select");
   knee_hi_a: assert property (bus.rd && bus.addr == A_LUMA_HKNEE |=> rdata < 8'h20)
      else $error("high knee too wide");
   knee_lo_a: assert property (bus.rd && bus.addr == A_LUMA_LKNEE |=> rdata < 8'h20)
      else $error("low knee too wide");
   // stream timing
   pre_lat_a: assert property (pre_valid |=> pre_out_valid)
      else $error("luma out late");
   pre_hold_a: assert property (!pre_valid |=> !pre_out_valid && $stable(pre_out_y))
      else $error("luma out moved");
   pix_lat_a: assert property (pix_in_valid |-> ##7 pix_out_valid)
      else $error("pixel out late");
   pix_gap_a: assert property (!pix_in_valid |-> ##7 !pix_out_valid)
      else $error("pixel out extra");
   cover property (pix_out_valid);
   cover property (pre_out_valid);
   cover property (bus.rd && bus.addr[8]);
endmodule : vie_pipeline_assertions
bind vie_pipeline vie_pipeline_assertions i_vie_pipeline_assertions (.clk_sys, .rstn, .bus,
   .rdata, .pre_valid, .pre_out_y, .pre_out_valid, .pix_in_valid, .pix_out_valid);
`default_nettype wire

// ===== tb/vie_scaler_model.sv
`timescale 1ns/10ps
`default_nettype none
module vie_scaler_model (
   input wire logic clk_sys,
   input wire logic src_on,
   output vie_pkg::vie_yuv_t pix_in = '0,
   output logic pix_in_valid = 1'b0,
   output logic field_odd = 1'b0,
   output logic on_screen_overlay = 1'b0
);
   import vie_pkg::*;
   // grey pixels of random luma, with gaps and random flags
   always @(posedge clk_sys) begin
      pix_in <= '{8'($urandom), MID_CODE, MID_CODE};
      pix_in_valid <= src_on && $urandom_range(1);
      field_odd <= 1'($urandom_range(1));
      on_screen_overlay <= 1'($urandom_range(1));
   end
endmodule : vie_scaler_model
`default_nettype wire
